//--- rtl/wwdt_top.sv
// Operation
// R1: 16-bit counter resets system past overflow value
// R2: bit 8 selects 32 kHz or 1 kHz
// R3: after reset running, 32 kHz, overflow FFFF
// R4: key 55AA written to counter clears it
// R5: other counter write values reset immediately
// R6: software refreshes before overflow is exceeded
// R7: window mode resets on too-early refresh
// R8: window minimum capped at 75% of overflow
// R9: config registers writable once after reset
// R10: software writes window, overflow, then control
// R11: software writes all registers at initialisation
// R12: unlock key 6BC3 opens 256-clock window
// R13: unlocked config applies after 256 clocks
// R14: repeated unlock restarts the unlock counter
// R15: bit 5 update permission, resets to 0
// R16: bit 7 enable, resets to 1
// R17: watchdog reset wakes system from low power
// R18: software waits 256 clocks before low power
// R19: optional halt of counting in debug
// R20: bit 1 idle mode enable, reset 0
// R21: bit 0 sleep mode enable, reset 0
// R22: counter readable, writes only act as keys
// R23: window value zero means non-window mode
// R24: disabled watchdog holds zero, no reset
`timescale 1ns/1ns
`include "wwdt_consts.svh"

module wwdt_top
    import wwdt_pkg::*;
#(
    parameter int FAST_DIV = `WWDT_FAST_DIV,
    parameter int SLOW_DIV = `WWDT_SLOW_DIV
)(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        sleep_mode,
    input  wire logic        idle_mode,
    input  wire logic        debug_halted,
    output logic             system_reset_req,
    output logic             wakeup_req
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [15:0] ctrl_q;
    logic [15:0] ovf_q;
    logic [15:0] win_q;
    logic [15:0] ctrl_sh_q;
    logic [15:0] ovf_sh_q;
    logic [15:0] win_sh_q;
    logic        locked_ctrl_q;
    logic        locked_ovf_q;
    logic        locked_win_q;
    logic        unlock_q;
    logic [8:0]  unlock_cnt_q;
    logic        pending_q;
    logic [15:0] cnt_q;
    logic [31:0] div_q;
    logic [1:0]  sleep_sync_q;
    logic [1:0]  idle_sync_q;
    logic [1:0]  dbg_sync_q;
    logic        aw_held_q;
    logic        w_held_q;
    logic [3:0]  aw_addr_q;
    logic [15:0] w_data_q;
    logic [1:0]  w_strb_q;
    logic        wr_fire;
    logic        wr_ctrl;
    logic        wr_ovf;
    logic        wr_win;
    logic        wr_cnt;
    logic        key_refresh;
    logic        key_unlock;
    logic        bad_key;
    logic        tick;
    logic        run;
    logic [17:0] win_cap;
    logic [15:0] win_eff;
    logic        too_early;
    logic        apply_now;
    logic [31:0] div_lim;
    wwdt_ctrl_s  cfg;

    assign cfg = '{window_mode_enable:    ctrl_q[`WWDT_BIT_WINEN],
                   debug_halt:            ctrl_q[`WWDT_BIT_DBGHALT],
                   count_clock_select:    ctrl_q[`WWDT_BIT_CLKSEL],
                   enable:                ctrl_q[`WWDT_BIT_ENABLE],
                   update_allow:          ctrl_q[`WWDT_BIT_UPDATE],
                   idle_run_enable:       ctrl_q[`WWDT_BIT_IDLE],
                   sleep_mode_run_enable: ctrl_q[`WWDT_BIT_SLEEP]};

    ////////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order
    always_ff @(posedge clk)
    begin
        if (rst || wr_fire)
        begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
                aw_held_q <= 1'b1;
            if (s_axi_wvalid && s_axi_wready)
                w_held_q <= 1'b1;
        end
    end

    // payload capture
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            aw_addr_q <= 4'h0;
            w_data_q  <= 16'h0000;
            w_strb_q  <= 2'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
                aw_addr_q <= (s_axi_awaddr[31:4] == 28'h0000000) ? s_axi_awaddr[3:0] : 4'h1;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_q <= s_axi_wdata[15:0];
                w_strb_q <= s_axi_wstrb[1:0];
            end
        end
    end

    // ready low while a response waits, so one write at a time
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) &&
                             !s_axi_bvalid && !wr_fire;
            s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready) &&
                             !s_axi_bvalid && !wr_fire;
        end
    end

    assign wr_fire = aw_held_q && w_held_q;
    assign wr_ctrl = wr_fire && aw_addr_q == `WWDT_OFF_CONTROL;
    assign wr_cnt  = wr_fire && aw_addr_q == `WWDT_OFF_COUNTER;
    assign wr_ovf  = wr_fire && aw_addr_q == `WWDT_OFF_OVERFLOW;
    assign wr_win  = wr_fire && aw_addr_q == `WWDT_OFF_WINDOW;

    // write response; unmapped address gets slverr
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `WWDT_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_ctrl || wr_cnt || wr_ovf || wr_win) ?
                            `WWDT_RESP_OKAY : `WWDT_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `WWDT_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `WWDT_RESP_OKAY;
                // R22: counter readable
                case (s_axi_araddr)
                    32'(`WWDT_OFF_CONTROL):  s_axi_rdata <= {16'h0000, ctrl_q};
                    32'(`WWDT_OFF_COUNTER):  s_axi_rdata <= {16'h0000, cnt_q};
                    32'(`WWDT_OFF_OVERFLOW): s_axi_rdata <= {16'h0000, ovf_q};
                    32'(`WWDT_OFF_WINDOW):   s_axi_rdata <= {16'h0000, win_q};
                    default:
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `WWDT_RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // key decode; partial strobes count as a bad key
    // R4: refresh key
    assign key_refresh = wr_cnt && w_strb_q == 2'h3 && w_data_q == `WWDT_KEY_REFRESH;
    // R12: unlock key only with update permission
    assign key_unlock  = wr_cnt && w_strb_q == 2'h3 && w_data_q == `WWDT_KEY_UNLOCK &&
                         cfg.update_allow;
    // R5: any other counter write is fatal
    assign bad_key     = wr_cnt && !key_refresh && !key_unlock;

    // R8: 75% cap, computed as 3*ovf/4
    assign win_cap = ({2'h0, ovf_q} + {1'b0, ovf_q, 1'b0}) >> 2;
    assign win_eff = ({2'h0, win_q} > win_cap) ? win_cap[15:0] : win_q;
    // R7: early refresh in window mode; R23: zero window accepts anything
    assign too_early = cfg.window_mode_enable && win_q != 16'h0000 && cnt_q < win_eff;

    ////////////////////////////////////////////////////////////////////////////
    // unlock window counter
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            unlock_q     <= 1'b0;
            unlock_cnt_q <= 9'h000;
        end
        // R14: repeated unlock restarts count
        else if (key_unlock)
        begin
            unlock_q     <= 1'b1;
            unlock_cnt_q <= 9'h000;
        end
        else if (unlock_q)
        begin
            unlock_cnt_q <= unlock_cnt_q + 9'h001;
            if (unlock_cnt_q == 9'(`WWDT_UNLOCK_CLKS - 1))
                unlock_q <= 1'b0;
        end
    end

    assign apply_now = unlock_q && unlock_cnt_q == 9'(`WWDT_UNLOCK_CLKS - 1);

    ////////////////////////////////////////////////////////////////////////////
    // R9: write-once config; shadow copies hold unlocked writes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            // R3: reset state runs at 32 kHz with overflow FFFF
            // R15: R16: R20: R21: control reset value
            ctrl_q        <= `WWDT_RST_CONTROL;
            ovf_q         <= `WWDT_RST_OVERFLOW;
            win_q         <= `WWDT_RST_WINDOW;
            ctrl_sh_q     <= `WWDT_RST_CONTROL;
            ovf_sh_q      <= `WWDT_RST_OVERFLOW;
            win_sh_q      <= `WWDT_RST_WINDOW;
            locked_ctrl_q <= 1'b0;
            locked_ovf_q  <= 1'b0;
            locked_win_q  <= 1'b0;
            pending_q     <= 1'b0;
        end
        else
        begin
            if (key_unlock)
            begin
                ctrl_sh_q <= ctrl_q;
                ovf_sh_q  <= ovf_q;
                win_sh_q  <= win_q;
            end
            // R13: apply after 256 clocks
            // ahead of the rewrites, so a rewrite in the same clock keeps pending set
            if (apply_now && pending_q)
            begin
                ctrl_q    <= ctrl_sh_q;
                ovf_q     <= ovf_sh_q;
                win_q     <= win_sh_q;
                pending_q <= 1'b0;
            end
            // R9: first write lands directly
            if (wr_ctrl && !locked_ctrl_q)
            begin
                ctrl_q        <= w_data_q & `WWDT_CTRL_MASK;
                locked_ctrl_q <= 1'b1;
            end
            if (wr_ovf && !locked_ovf_q)
            begin
                ovf_q        <= w_data_q;
                locked_ovf_q <= 1'b1;
            end
            if (wr_win && !locked_win_q)
            begin
                win_q        <= w_data_q;
                locked_win_q <= 1'b1;
            end
            // R12: unlocked rewrites go to shadow
            if (unlock_q && !key_unlock)
            begin
                if (wr_ctrl && locked_ctrl_q)
                begin
                    ctrl_sh_q <= w_data_q & `WWDT_CTRL_MASK;
                    pending_q <= 1'b1;
                end
                if (wr_ovf && locked_ovf_q)
                begin
                    ovf_sh_q  <= w_data_q;
                    pending_q <= 1'b1;
                end
                if (wr_win && locked_win_q)
                begin
                    win_sh_q  <= w_data_q;
                    pending_q <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // low-power and debug inputs come from other domains
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sleep_sync_q <= 2'h0;
            idle_sync_q  <= 2'h0;
            dbg_sync_q   <= 2'h0;
        end
        else
        begin
            sleep_sync_q <= {sleep_sync_q[0], sleep_mode};
            idle_sync_q  <= {idle_sync_q[0], idle_mode};
            dbg_sync_q   <= {dbg_sync_q[0], debug_halted};
        end
    end

    // counting allowed: low-power modes need their run bits
    // R19: debug halt option; R20: idle; R21: sleep
    assign run = cfg.enable &&
                 !(cfg.debug_halt && dbg_sync_q[1]) &&
                 !(idle_sync_q[1] && !cfg.idle_run_enable) &&
                 !(sleep_sync_q[1] && !cfg.sleep_mode_run_enable);

    ////////////////////////////////////////////////////////////////////////////
    // R2: count tick from sys clock divider, no real oscillator here
    assign div_lim = cfg.count_clock_select ? 32'(FAST_DIV - 1) : 32'(SLOW_DIV - 1);
    assign tick    = div_q >= div_lim;

    always_ff @(posedge clk)
    begin
        if (rst || !cfg.enable || tick)
            div_q <= 32'h00000000;
        else if (run)
            div_q <= div_q + 32'h00000001;
    end

    // R1: 16-bit up counter
    always_ff @(posedge clk)
    begin
        if (rst)
            cnt_q <= 16'h0000;
        // R24: disabled holds zero
        else if (!cfg.enable)
            cnt_q <= 16'h0000;
        // R4: refresh clears; R22: no direct load
        else if (key_refresh)
            cnt_q <= 16'h0000;
        else if (run && tick && cnt_q != 16'hFFFF)
            cnt_q <= cnt_q + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset request: sticky until the system reset lands on rst
    always_ff @(posedge clk)
    begin
        if (rst)
            system_reset_req <= 1'b0;
        // R24: disabled asserts nothing
        else if (cfg.enable)
        begin
            // R1: passed overflow value
            if (cnt_q > ovf_q)
                system_reset_req <= 1'b1;
            // R5: bad key
            if (bad_key)
                system_reset_req <= 1'b1;
            // R7: early refresh
            if (key_refresh && too_early)
                system_reset_req <= 1'b1;
        end
    end

    // R17: wake the system when reset fires in low power
    always_ff @(posedge clk)
    begin
        if (rst)
            wakeup_req <= 1'b0;
        else if (cfg.enable && (cnt_q > ovf_q || bad_key || (key_refresh && too_early)) &&
                 (sleep_sync_q[1] || idle_sync_q[1]))
            wakeup_req <= 1'b1;
    end

endmodule // wwdt_top

//--- rtl/wwdt_consts.svh
`ifndef WWDT_CONSTS_SVH
`define WWDT_CONSTS_SVH

// register byte offsets
`define WWDT_OFF_CONTROL   4'h0
`define WWDT_OFF_COUNTER   4'h4
`define WWDT_OFF_OVERFLOW  4'h8
`define WWDT_OFF_WINDOW    4'hC
// control field positions
`define WWDT_BIT_SLEEP     0
`define WWDT_BIT_IDLE      1
`define WWDT_BIT_UPDATE    5
`define WWDT_BIT_ENABLE    7
`define WWDT_BIT_CLKSEL    8
`define WWDT_BIT_DBGHALT   9
`define WWDT_BIT_WINEN     15
`define WWDT_CTRL_MASK     16'h83A3
// reset values
`define WWDT_RST_CONTROL   16'h0180
`define WWDT_RST_OVERFLOW  16'hFFFF
`define WWDT_RST_WINDOW    16'h0000
// keys
`define WWDT_KEY_REFRESH   16'h55AA
`define WWDT_KEY_UNLOCK    16'h6BC3
// timing
`define WWDT_UNLOCK_CLKS   256
`define WWDT_SYS_HZ        25000000
`define WWDT_FAST_HZ       32000
`define WWDT_SLOW_HZ       1000
`define WWDT_FAST_DIV      (`WWDT_SYS_HZ / `WWDT_FAST_HZ)
`define WWDT_SLOW_DIV      (`WWDT_SYS_HZ / `WWDT_SLOW_HZ)
// axi responses
`define WWDT_RESP_OKAY     2'h0
`define WWDT_RESP_SLVERR   2'h2

`endif

//--- rtl/wwdt_pkg.sv
package wwdt_pkg;
    typedef struct packed {
        logic window_mode_enable;
        logic debug_halt;
        logic count_clock_select;
        logic enable;
        logic update_allow;
        logic idle_run_enable;
        logic sleep_mode_run_enable;
    } wwdt_ctrl_s;
endpackage

//--- verification/wwdt_checker.sv
`timescale 1ns/1ns

module wwdt_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        system_reset_req,
    input wire logic        wakeup_req
);
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (rst);

    // a counter write whose value is neither key
    logic bad_key;
    assign bad_key = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == 32'h4 && s_axi_wdata[15:0] != 16'h55AA
        && s_axi_wdata[15:0] != 16'h6BC3 && s_axi_wstrb[1:0] == 2'h3;

    ////////////////////////////////////////////////////////////////
    AST_RESET_STICKY:
        assert property (system_reset_req |=> system_reset_req)
        else $error("reset request dropped without reset");
    AST_WAKE_STICKY:
        assert property (wakeup_req |=> wakeup_req)
        else $error("wakeup request dropped without reset");
    AST_WAKE_WITH_RESET:
        assert property (wakeup_req |-> system_reset_req)
        else $error("wakeup without reset request");
    AST_BAD_KEY:
        assert property (bad_key |-> ##[1:4] system_reset_req)
        else $error("bad key did not reset");
    AST_CLEAN_AFTER_RESET:
        assert property (disable iff (1'b0) rst |=> !system_reset_req && !wakeup_req)
        else $error("request high right after reset");
    AST_BVALID_HOLD:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    AST_RVALID_HOLD:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response not held");
    AST_READ_LATENCY:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_WRITE_LATENCY:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    AST_AW_REFUSED:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");

    // main scenarios reached
    cover property (bad_key);
    cover property ($rose(wakeup_req));
    cover property ($rose(system_reset_req));
endmodule // wwdt_checker

bind wwdt_top wwdt_checker wwdt_checker_inst (
    .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .system_reset_req(system_reset_req),
    .wakeup_req(wakeup_req)
);

//--- verification/windowed_watchdog_timer_test.sv
`timescale 1ns/1ns

module windowed_watchdog_timer_test;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [31:0] awaddr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] araddr = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        sleep_mode = 1'b0;
    logic        idle_mode = 1'b0;
    logic [3:0]  wstrb = 4'hF;
    logic        debug_halted = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata, rval;
    logic        system_reset_req, wakeup_req;
    int          n_mismatch = 0;
    int          total_checks = 0;

    // short tick dividers keep the overflow runs brief
    wwdt_top #(.FAST_DIV(4), .SLOW_DIV(8)) wwdt_top_inst (
        .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sleep_mode(sleep_mode), .idle_mode(idle_mode), .debug_halted(debug_halted),
        .system_reset_req(system_reset_req), .wakeup_req(wakeup_req)
    );

    // 25 MHz
    always #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic do_reset;
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(1);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // handshakes judged mid-cycle, so no race with the edge itself
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic ta;
        logic tw;
        logic tb;
        tb = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb)
        begin
            @(negedge clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            resp = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        // one idle edge, so a following call never re-raises bready in this step
        @(posedge clk);
    endtask

    task automatic rd(input logic [31:0] a);
        logic ta;
        logic tr;
        tr = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr)
        begin
            @(negedge clk);
            ta = arvalid & arready;
            tr = rvalid;
            rval = rdata;
            resp = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        // one idle edge, so a following call never re-raises rready in this step
        @(posedge clk);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // hang guard, run needs roughly 1200 cycles
    initial
    begin
        cyc(20000);
        n_mismatch++;
        stop_test();
    end

    initial
    begin
        cyc(2);
        rst <= 1'b0;
        cyc(1);
        // reset values and an unmapped place
        rd(32'h0); check(rval, 32'h0180);
        rd(32'h8); check(rval, 32'hFFFF);
        rd(32'hC); check(rval, 32'h0000);
        rd(32'h10); check({30'h0, resp}, 32'h2);
        check(rval, 32'h0);
        wr(32'h4, 32'h55AA);
        rd(32'h4); check(32'(rval < 32'h3), 32'h1);
        // window, overflow, control order locks the setup
        wr(32'hC, 32'h00FF);
        wr(32'h8, 32'h0040);
        wr(32'h0, 32'h81A0);
        wr(32'h8, 32'h1234); check({30'h0, resp}, 32'h0);
        rd(32'h8); check(rval, 32'h0040);
        rd(32'h0); check(rval, 32'h81A0);
        // window capped at 3/4 of 0x40, so 0x31 is late enough
        do rd(32'h4); while (rval < 32'h31);
        wr(32'h4, 32'h55AA);
        cyc(3);
        check(32'(system_reset_req), 32'h0);
        sleep_mode <= 1'b1; // long after setup
        cyc(2); // sleep level crosses its synchroniser
        wr(32'h4, 32'h55AA);
        cyc(3);
        check(32'(system_reset_req), 32'h1);
        check(32'(wakeup_req), 32'h1);
        sleep_mode <= 1'b0;
        do_reset();
        // unlock, re-key, then late apply of a short overflow
        wr(32'hC, 32'h0000);
        wr(32'h8, 32'h0100);
        wr(32'h0, 32'h01A0);
        wr(32'h4, 32'h55AA);
        wr(32'h4, 32'h6BC3);
        cyc(100);
        wr(32'h4, 32'h6BC3);
        wr(32'h8, 32'h0010);
        cyc(190);
        check(32'(system_reset_req), 32'h0);
        cyc(100);
        check(32'(system_reset_req), 32'h1);
        rd(32'h8); check(rval, 32'h0010);
        do_reset();
        // a wrong key resets at once
        wr(32'h4, 32'h1234);
        cyc(3);
        check(32'(system_reset_req), 32'h1);
        check(32'(wakeup_req), 32'h0);
        do_reset();
        // a partial strobe on the counter is no key
        wstrb <= 4'h1;
        wr(32'h4, 32'h55AA);
        cyc(3);
        check(32'(system_reset_req), 32'h1);
        wstrb <= 4'hF;
        do_reset();
        // debug halt freezes the count
        debug_halted <= 1'b1;
        wr(32'h8, 32'h0008);
        wr(32'h4, 32'h55AA);
        wr(32'h0, 32'h0380);
        cyc(100);
        check(32'(system_reset_req), 32'h0);
        // idle without its run bit keeps the count paused
        debug_halted <= 1'b0;
        idle_mode <= 1'b1;
        cyc(100);
        check(32'(system_reset_req), 32'h0);
        idle_mode <= 1'b0;
        cyc(100);
        check(32'(system_reset_req), 32'h1);
        do_reset();
        // slow select ticks half as often as the fast one here
        wr(32'h8, 32'h0004);
        wr(32'h0, 32'h0080);
        wr(32'h4, 32'h55AA);
        cyc(24);
        check(32'(system_reset_req), 32'h0);
        cyc(40);
        check(32'(system_reset_req), 32'h1);
        do_reset();
        // disabled watchdog stays at zero
        wr(32'h8, 32'h0008);
        wr(32'h0, 32'h0100);
        cyc(100);
        rd(32'h4); check(rval, 32'h0000);
        check(32'(system_reset_req), 32'h0);
        stop_test();
    end
endmodule // windowed_watchdog_timer_test
